//--- verilog/pat_arbiter.sv
// port arbitration phase table with AXI4-Lite registers and the arbiter
// assumes requests and egress id come from logic on clk_sys_in
`timescale 1ns/100ps
`include "pat_defines.svh"
module pat_arbiter (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // axi4-lite write address
  input wire logic awvalid_in,
  input wire logic [11:0] awaddr_in,
  output logic awready_out,
  // axi4-lite write data
  input wire logic wvalid_in,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  output logic wready_out,
  // axi4-lite write response
  output logic bvalid_out,
  output logic [1:0] bresp_out,
  input wire logic bready_in,
  // axi4-lite read
  input wire logic arvalid_in,
  input wire logic [11:0] araddr_in,
  output logic arready_out,
  output logic rvalid_out,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  input wire logic rready_in,
  // ingress ports
  input wire logic [11:0] req_in,
  input wire logic [3:0] egress_id_in,
  // arbitration result
  output logic [11:0] grant_out,
  output logic grant_valid_out,
  output logic [4:0] grant_phase_out,
  output logic arb_table_dirty_out
);
  pat_pkg::pat_state_t st;
  pat_pkg::pat_state_t next_st;
  logic pick_found;
  logic [4:0] pick_idx;
  logic [3:0] pick_port;
  logic period;
  logic wr_go;
  logic tbl_wr;
  logic load_req;
  logic [1:0] wr_idx;
  pat_pkg::pat_reg_t wr_reg;
  pat_pkg::pat_reg_t rd_reg;

  // ====================================================
  // address decode
  function automatic pat_pkg::pat_reg_t pat_decode(input logic [11:0] addr);
    case ({addr[11:2], 2'b00})
      `PAT_OFS_TBL0: pat_decode = pat_pkg::PAT_REG_TBL0;
      `PAT_OFS_TBL1: pat_decode = pat_pkg::PAT_REG_TBL1;
      `PAT_OFS_TBL2: pat_decode = pat_pkg::PAT_REG_TBL2;
      `PAT_OFS_TBL3: pat_decode = pat_pkg::PAT_REG_TBL3;
      `PAT_OFS_CTL: pat_decode = pat_pkg::PAT_REG_CTL;
      `PAT_OFS_STS: pat_decode = pat_pkg::PAT_REG_STS;
      default: pat_decode = pat_pkg::PAT_REG_NONE;
    endcase
  endfunction

  pat_slot_pick u_pick (
    .table_in(st.live),
    .start_in(st.phase),
    .egress_in(egress_id_in),
    .found_out(pick_found),
    .idx_out(pick_idx),
    .port_out(pick_port)
  );

  assign awready_out = !st.aw_held && !st.bvalid;
  assign wready_out = !st.w_held && !st.bvalid;
  assign arready_out = !st.rvalid;
  assign bvalid_out = st.bvalid;
  assign bresp_out = st.bresp;
  assign rvalid_out = st.rvalid;
  assign rdata_out = st.rdata;
  assign rresp_out = st.rresp;
  assign grant_out = st.grant;
  assign grant_valid_out = st.grant_vld;
  assign grant_phase_out = st.grant_phase;
  assign arb_table_dirty_out = st.dirty;

  assign period = (st.div == `PAT_ARB_PERIOD_CYC);
  assign wr_go = st.aw_held && st.w_held;
  assign wr_reg = pat_decode(st.aw_addr);
  assign rd_reg = pat_decode(araddr_in);
  assign wr_idx = st.aw_addr[3:2];
  assign tbl_wr = wr_go && (wr_reg <= pat_pkg::PAT_REG_TBL3);
  assign load_req = wr_go && (wr_reg == pat_pkg::PAT_REG_CTL)
    && st.w_strb[2] && st.w_data[`PAT_LOAD_BIT];

  // ====================================================
  // next state
  always_comb begin
    next_st = st;
    // write channel capture, either order
    if (awvalid_in && awready_out) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = awaddr_in;
    end
    if (wvalid_in && wready_out) begin
      next_st.w_held = 1'b1;
      next_st.w_data = wdata_in;
      next_st.w_strb = wstrb_in;
    end
    if (st.bvalid && bready_in) begin
      next_st.bvalid = 1'b0;
    end
    if (wr_go) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = (wr_reg == pat_pkg::PAT_REG_NONE) ? `PAT_RESP_SLVERR : `PAT_RESP_OKAY;
      if (tbl_wr) begin
        for (int b = 0; b < 4; b++) begin
          if (st.w_strb[b]) begin
            next_st.tbl[wr_idx][8*b +: 8] = st.w_data[8*b +: 8];
          end
        end
      end
    end
    // read channel
    if (st.rvalid && rready_in) begin
      next_st.rvalid = 1'b0;
    end
    if (arvalid_in && arready_out) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = `PAT_RESP_OKAY;
      case (rd_reg)
        pat_pkg::PAT_REG_TBL0, pat_pkg::PAT_REG_TBL1,
        pat_pkg::PAT_REG_TBL2, pat_pkg::PAT_REG_TBL3: begin
          next_st.rdata = st.tbl[araddr_in[3:2]];
        end
        pat_pkg::PAT_REG_CTL: begin
          next_st.rdata = 32'h0000_0000;
        end
        pat_pkg::PAT_REG_STS: begin
          next_st.rdata = 32'h0000_0000;
          next_st.rdata[`PAT_DIRTY_BIT] = st.dirty;
        end
        default: begin
          next_st.rdata = 32'h0000_0000;
          next_st.rresp = `PAT_RESP_SLVERR;
        end
      endcase
    end
    // table load, one word per cycle
    if (st.loading) begin
      next_st.live[32*st.load_idx +: 32] = st.tbl[st.load_idx];
      next_st.load_idx = st.load_idx + 2'h1;
      if (st.load_idx == `PAT_LOAD_LAST) begin
        next_st.loading = 1'b0;
        next_st.dirty = 1'b0;
      end
    end else if (load_req) begin
      next_st.loading = 1'b1;
      next_st.load_idx = 2'h0;
    end
    // set wins over clear
    if (tbl_wr) begin
      next_st.dirty = 1'b1;
    end
    // arbitration period
    next_st.div = st.div + 2'h1;
    next_st.grant_vld = 1'b0;
    next_st.grant = 12'h000;
    if (period) begin
      if (pick_found) begin
        next_st.grant_vld = 1'b1;
        next_st.grant_phase = pick_idx;
        next_st.grant_port = pick_port;
        next_st.grant = (12'h001 << pick_port) & req_in;
        next_st.phase = pick_idx + 5'h01;
      end
    end
  end

  // ====================================================
  // state register
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ====================================================
  // assertions
  a_reset_zero: assert property (@(posedge clk_sys_in)
    !nrst_in |=> (st.tbl == '0) && (st.live == '0) && !st.dirty)
    else $error("table not zero after reset");

  a_word_store: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    tbl_wr && (st.w_strb == 4'hf) |=> st.tbl[$past(wr_idx)] == $past(st.w_data))
    else $error("table word not stored");

  a_write_dirty: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    tbl_wr |=> st.dirty)
    else $error("dirty not set by table write");

  a_load_clear: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    st.loading && (st.load_idx == `PAT_LOAD_LAST) && !tbl_wr |=> !st.dirty)
    else $error("dirty not cleared after load");

  a_load_length: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    $rose(st.loading) |-> st.loading [*4] ##1 !st.loading)
    else $error("load not four cycles");

  a_live_hold: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    !st.loading |=> $stable(st.live))
    else $error("live table changed without load");

  a_ctl_reads_zero: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    arvalid_in && arready_out && (rd_reg == pat_pkg::PAT_REG_CTL) |=> st.rdata == '0)
    else $error("load bit read back nonzero");

  a_grant_legal: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    st.grant_vld |-> (st.grant_port <= `PAT_MAX_PORT) && (st.grant_port != egress_id_in))
    else $error("grant to illegal port");

  a_skip_now: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    period && pick_found |=> st.grant_vld && (st.grant_port == $past(pick_port)))
    else $error("valid slot not granted at once");

  a_phase_step: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    period && pick_found |=> st.phase == $past(pick_idx) + 5'h01)
    else $error("phase pointer not advanced");

  c_load_done: cover property (@(posedge clk_sys_in) disable iff (!nrst_in)
    $fell(st.loading) && !st.dirty);
  c_grant: cover property (@(posedge clk_sys_in) disable iff (!nrst_in)
    st.grant_vld && (st.grant != 12'h000));
  c_skip: cover property (@(posedge clk_sys_in) disable iff (!nrst_in)
    period && pick_found && (pick_idx != st.phase));
  c_wrap: cover property (@(posedge clk_sys_in) disable iff (!nrst_in)
    st.grant_vld && (st.grant_phase == 5'h1f));
endmodule

//--- verilog/pat_defines.svh
// constants of the port arbitration phase table
// assumes a 32-bit AXI4-Lite register bus with 12-bit byte addresses
// Function
// - each 4-bit phase slot names the ingress port granted in that period
// - a slot holding an invalid port is skipped with no delay
// - slot code 0x0 to 0xB select ports 0 to 11, the rest are reserved
// - word 0x240 holds phases 0 to 7, phase 0 in bits 3:0
// - word 0x244 holds phases 8 to 15, lowest nibble first
// - word 0x248 holds phases 16 to 23, lowest nibble first
// - all slots are read/write and reset to zero, naming port 0
// - word 0x24C holds phases 24 to 31, completing 32 phases
// - arbiter takes new table only on load bit; load bit reads zero
// - dirty flag sets on table write, clears when table load finishes
`ifndef PAT_DEFINES_SVH
`define PAT_DEFINES_SVH

// ====================================================
// register offsets
`define PAT_OFS_TBL0 12'h240
`define PAT_OFS_TBL1 12'h244
`define PAT_OFS_TBL2 12'h248
`define PAT_OFS_TBL3 12'h24c
`define PAT_OFS_CTL 12'h214
`define PAT_OFS_STS 12'h218

// ====================================================
// fields and reset values
`define PAT_LOAD_BIT 16
`define PAT_DIRTY_BIT 16
`define PAT_TBL_RESET 32'h0000_0000
`define PAT_MAX_PORT 4'hb
`define PAT_RESP_OKAY 2'h0
`define PAT_RESP_SLVERR 2'h2

// ====================================================
// timing
`define PAT_ARB_PERIOD_CYC 2'h3
`define PAT_LOAD_LAST 2'h3

`endif

//--- verilog/pat_pkg.sv
// types of the port arbitration phase table
// assumes pat_defines.svh for numeric constants, except the port limit 4'hb in pat_slot_ok
package pat_pkg;

  typedef enum {
    PAT_REG_TBL0,
    PAT_REG_TBL1,
    PAT_REG_TBL2,
    PAT_REG_TBL3,
    PAT_REG_CTL,
    PAT_REG_STS,
    PAT_REG_NONE
  } pat_reg_t;

  typedef struct packed {
    logic [3:0][31:0] tbl;
    logic [127:0] live;
    logic dirty;
    logic loading;
    logic [1:0] load_idx;
    logic [4:0] phase;
    logic [1:0] div;
    logic [11:0] grant;
    logic grant_vld;
    logic [4:0] grant_phase;
    logic [3:0] grant_port;
    logic aw_held;
    logic [11:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pat_state_t;

  // ====================================================
  // slot code names a legal ingress port
  function automatic logic pat_slot_ok(input logic [3:0] code, input logic [3:0] egress);
    pat_slot_ok = (code <= 4'hb) && (code != egress);
  endfunction

endpackage

//--- verilog/pat_slot_pick.sv
// first valid phase slot at or after a start phase, wrapping
// assumes the live table flattened, slot n in bits 4n+3:4n
`timescale 1ns/100ps
module pat_slot_pick (
  // table and search
  input wire logic [127:0] table_in,
  input wire logic [4:0] start_in,
  input wire logic [3:0] egress_in,
  // result
  output logic found_out,
  output logic [4:0] idx_out,
  output logic [3:0] port_out
);
  logic [31:0] ok;
  logic [31:0][3:0] code;

  // ====================================================
  // per offset validity
  genvar k;
  generate
    for (k = 0; k < 32; k++) begin : g_slot
      logic [4:0] sidx;
      assign sidx = start_in + 5'(k);
      assign code[k] = table_in[{sidx, 2'b00} +: 4];
      assign ok[k] = pat_pkg::pat_slot_ok(code[k], egress_in);
    end
  endgenerate

  // ====================================================
  // nearest valid offset wins
  always_comb begin
    found_out = 1'b0;
    idx_out = start_in;
    port_out = 4'h0;
    for (int j = 31; j >= 0; j--) begin
      if (ok[j]) begin
        found_out = 1'b1;
        idx_out = start_in + 5'(j);
        port_out = code[j];
      end
    end
  end
endmodule

//--- test/pat_ingress_model.sv
// ingress request model facing the egress arbiter
// assumes clk_sys_in and nrst_in shared with the arbiter
`timescale 1ns/100ps
module pat_ingress_model (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // ports with traffic queued
  input wire logic [11:0] want_in,
  // requests to the arbiter
  output logic [11:0] req_out
);
  // a port keeps asking while it has traffic
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      req_out <= 12'h000;
    end else begin
      req_out <= want_in;
    end
  end
endmodule

//--- test/port_arbitration_phase_table_tb_top.sv
// self-checking bench for the arbitration phase table
// assumes pat_arbiter and pat_ingress_model compiled first
`timescale 1ns/100ps
module port_arbitration_phase_table_tb_top;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] d;
    logic [1:0] r;
    logic [31:0] q;
  } pat_row_t;
  logic clk_sys_in, nrst_in, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, gvalid, dirty;
  logic [11:0] awaddr, araddr, want, req, grant;
  logic [31:0] wdata, rdat, v;
  logic [3:0] wstrb, egress, port;
  logic [1:0] bresp, rresp, resp;
  logic [4:0] gphase, prev;
  logic [31:0] ew [4];
  pat_row_t rows [5];
  int n_errors, tests_run, cyc, gap;

  pat_arbiter u_dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .awvalid_in(awvalid),
    .awaddr_in(awaddr), .awready_out(awready), .wvalid_in(wvalid), .wdata_in(wdata),
    .wstrb_in(wstrb), .wready_out(wready), .bvalid_out(bvalid), .bresp_out(bresp),
    .bready_in(bready), .arvalid_in(arvalid), .araddr_in(araddr), .arready_out(arready),
    .rvalid_out(rvalid), .rdata_out(rdat), .rresp_out(rresp), .rready_in(rready),
    .req_in(req), .egress_id_in(egress), .grant_out(grant), .grant_valid_out(gvalid),
    .grant_phase_out(gphase), .arb_table_dirty_out(dirty));
  pat_ingress_model u_req (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .want_in(want),
    .req_out(req));

  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end

  // ====================================================
  // checking and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  // ====================================================
  // axi4-lite master
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_t, w_t, aw_d, w_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    @(posedge clk_sys_in);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    bready <= 1'b1;
    while (!(aw_d && w_d)) begin
      @(negedge clk_sys_in);
      aw_t = awvalid && (awready === 1'b1);
      w_t = wvalid && (wready === 1'b1);
      @(posedge clk_sys_in);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      aw_d = aw_d | aw_t;
      w_d = w_d | w_t;
    end
    do @(negedge clk_sys_in); while (bvalid !== 1'b1);
    r = bresp;
    @(posedge clk_sys_in);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys_in);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(negedge clk_sys_in); while (arready !== 1'b1);
    @(posedge clk_sys_in);
    arvalid <= 1'b0;
    do @(negedge clk_sys_in); while (rvalid !== 1'b1);
    d = rdat;
    r = rresp;
    @(posedge clk_sys_in);
    rready <= 1'b0;
  endtask

  // counts falling edges up to the next grant pulse
  task automatic wait_grant(output int n);
    n = 0;
    do begin
      @(negedge clk_sys_in);
      n++;
    end while (gvalid !== 1'b1);
  endtask

  // one grant per period, phases in order, grant gated by requests
  task automatic run_grants(input int n);
    wait_grant(gap);
    prev = gphase;
    repeat (n) begin
      wait_grant(gap);
      chk(gap, 4);
      chk({27'h0, gphase}, {27'h0, prev + 5'h1});
      port = ew[gphase[4:3]][{gphase[2:0], 2'b00} +: 4];
      chk({20'h0, grant}, {20'h0, (12'h001 << port) & want});
      prev = gphase;
    end
  endtask

  // ====================================================
  // main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, cyc, n_errors, tests_run} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    nrst_in = 1'b0;
    want = 12'hfff;
    egress = 4'hb;
    // slot codes avoid reserved values and the egress port
    rows[0] = '{12'h240, 32'h76543210, 2'h0, 32'h76543210};
    rows[1] = '{12'h244, 32'h43210a98, 2'h0, 32'h43210a98};
    rows[2] = '{12'h248, 32'h10a98765, 2'h0, 32'h10a98765};
    rows[3] = '{12'h24c, 32'h98765432, 2'h0, 32'h98765432};
    rows[4] = '{12'h100, 32'hffffffff, 2'h2, 32'h00000000};
    repeat (10) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(12'h240 + 12'(4 * i), v, resp);
      chk(v, 32'h0);
    end
    chk({31'h0, dirty}, 32'h0);
    for (int i = 0; i < 5; i++) begin
      if (i < 4) ew[i] = rows[i].d;
      wr(rows[i].a, rows[i].d, resp);
      chk({30'h0, resp}, {30'h0, rows[i].r});
      rd(rows[i].a, v, resp);
      chk(v, rows[i].q);
    end
    chk({31'h0, dirty}, 32'h1);
    rd(12'h218, v, resp);
    chk(v, 32'h0001_0000);
    wait_grant(gap);
    chk({20'h0, grant}, 32'h001);
    wr(12'h214, 32'h0, resp);
    rd(12'h214, v, resp);
    chk(v, 32'h0);
    chk({31'h0, dirty}, 32'h1);
    wr(12'h214, 32'h00010000, resp);
    for (int i = 0; i < 8 && dirty === 1'b1; i++) @(negedge clk_sys_in);
    chk({31'h0, dirty}, 32'h0);
    rd(12'h218, v, resp);
    chk(v, 32'h0);
    run_grants(20);
    // some ports idle: their periods still pass, with no grant
    @(posedge clk_sys_in);
    want <= 12'h5a5;
    run_grants(40);
    // mid-run reset: table, dirty flag and phase pointer back to zero
    @(posedge clk_sys_in);
    nrst_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    wait_grant(gap);
    chk({27'h0, gphase}, 32'h0);
    chk({20'h0, grant}, {20'h0, 12'h001 & want});
    chk({31'h0, dirty}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      rd(12'h240 + 12'(4 * i), v, resp);
      chk(v, 32'h0);
    end
    tally_and_finish();
  end
endmodule
